// >>> src/vpic_pkg.sv
// Constants, field layouts and enumerations of the vectored priority interrupt controller.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one 250 MHz core clock.
// Summary of operation
// - Normal request line from sources 1 to 31
// - Each source has priority 7 (high) to 0
// - Request asserted as soon as condition occurs
// - Current interrupt chosen at vector read time
// - Equal priority: lowest source number wins
// - Current level equals selected interrupt's priority
// - Only higher priority re-asserts during service
// - Vector read pushes number and level on stack
// - Nesting stack holds eight entries
// - Vector read returns selected source's handler address
// - Vector read register at 0xFFFF_F100
// - Vector read de-asserts request; software always reads
// - Vector read clears edge-triggered current source only
// - End-of-service write pops stack, restores level
// - After pop, re-assert for priority above new level
// - Only source 0 raises fast request, unless forced
// - Trigger choices: rising, falling, high, low
// - Separate enable and disable commands; mask readable
// - Vector read never clears fast-forced sources
// - No enabled pending source returns spurious vector
package vpic_pkg;
  localparam int unsigned NUM_SRC = 32;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned SP_W = 4;
  localparam int unsigned OFS_W = 9;
  localparam logic [31:0] BASE_ADDR = 32'hFFFF_F000;
  localparam logic [8:0] OFS_MODE = 9'h000;
  localparam logic [8:0] OFS_VEC = 9'h080;
  localparam logic [8:0] OFS_IVR = 9'h100;
  localparam logic [8:0] OFS_FVR = 9'h104;
  localparam logic [8:0] OFS_CUR = 9'h108;
  localparam logic [8:0] OFS_PEND = 9'h10C;
  localparam logic [8:0] OFS_MASK = 9'h110;
  localparam logic [8:0] OFS_LINES = 9'h114;
  localparam logic [8:0] OFS_IEN = 9'h120;
  localparam logic [8:0] OFS_IDIS = 9'h124;
  localparam logic [8:0] OFS_ISET = 9'h128;
  localparam logic [8:0] OFS_ICLR = 9'h12C;
  localparam logic [8:0] OFS_EOI = 9'h130;
  localparam logic [8:0] OFS_SPUR = 9'h134;
  localparam logic [8:0] OFS_FFEN = 9'h140;
  localparam logic [8:0] OFS_FFDIS = 9'h144;
  localparam logic [8:0] OFS_FFSTAT = 9'h148;
  localparam int unsigned PRIO_LSB = 0;
  localparam int unsigned PRIO_W = 3;
  localparam int unsigned TRIG_LSB = 5;
  localparam int unsigned TRIG_W = 2;
  localparam logic [2:0] PRIO_RST = 3'h0;
  localparam logic [31:0] VEC_RST = 32'h0000_0000;
  localparam logic [31:0] SPUR_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  typedef enum logic [1:0] {
    TRIG_LOW_LEVEL = 2'b00,
    TRIG_FALL_EDGE = 2'b01,
    TRIG_HIGH_LEVEL = 2'b10,
    TRIG_RISE_EDGE = 2'b11
  } vpic_trig_e;
  localparam logic [1:0] TRIG_RST = 2'h0;
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } vpic_bus_e;
endpackage : vpic_pkg

// >>> src/vpic_src_stage.sv
// One interrupt source input stage: pin synchroniser, trigger detection, edge memory.
// Assumes the raw input is asynchronous to core_clk; commands are one-cycle pulses.
`timescale 1ns/1ps
module vpic_src_stage (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic raw_in, // Asynchronous source input
  input wire logic [1:0] trig, // Trigger type field
  input wire logic set_p, // Software set pulse
  input wire logic clr_p, // Clear pulse (software or vector read)
  output logic active // Source condition present
);
  logic meta_q;
  logic sync_q;
  logic prev_q;
  logic edge_q;
  logic is_edge;
  logic hit_edge;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (ce) begin
      meta_q <= raw_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign is_edge = trig[0];
  always_comb begin
    case (vpic_pkg::vpic_trig_e'(trig))
      vpic_pkg::TRIG_RISE_EDGE: hit_edge = sync_q & ~prev_q;
      vpic_pkg::TRIG_FALL_EDGE: hit_edge = ~sync_q & prev_q;
      default: hit_edge = 1'b0;
    endcase
  end

  // A new edge in the same cycle as a clear is kept: set wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      edge_q <= 1'b0;
    end else if (ce) begin
      if (!is_edge) begin
        edge_q <= 1'b0;
      end else if (hit_edge || set_p) begin
        edge_q <= 1'b1;
      end else if (clr_p) begin
        edge_q <= 1'b0;
      end
    end
  end

  always_comb begin
    case (vpic_pkg::vpic_trig_e'(trig))
      vpic_pkg::TRIG_HIGH_LEVEL: active = sync_q;
      vpic_pkg::TRIG_LOW_LEVEL: active = ~sync_q;
      default: active = edge_q;
    endcase
  end
endmodule : vpic_src_stage

// >>> src/vpic_prio_sel.sv
// Priority arbiter over normal sources 1 to 31.
// Purely combinational; assumes candidates are already pending, enabled and not forced.
`timescale 1ns/1ps
module vpic_prio_sel (
  input wire logic [31:0] cand, // Eligible sources
  input wire logic [2:0] prio [32], // Priority of each source
  output logic found, // At least one candidate
  output logic [4:0] win_idx, // Winning source number
  output logic [2:0] win_prio // Winning priority
);
  always_comb begin
    found = 1'b0;
    win_idx = 5'h00;
    win_prio = 3'h0;
    // Strict compare while walking upward keeps the lowest number on a tie
    for (int i = 1; i < 32; i++) begin
      if (cand[i] && (!found || prio[i] > win_prio)) begin
        found = 1'b1;
        win_idx = 5'(i);
        win_prio = prio[i];
      end
    end
  end
endmodule : vpic_prio_sel

// >>> src/vpic_ctrl.sv
// Top of the vectored priority interrupt controller: Avalon-MM slave, source registers,
// nesting stack and the normal and fast request lines to the processor core.
// Assumes a single core clock; source inputs arrive from pins, asynchronous to it.
//
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module vpic_ctrl (
  input wire logic core_clk, // Core clock, 250 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic [31:0] src_in, // Raw interrupt sources 0..31
  input wire logic [31:0] avs_address, // Byte address
  input wire logic [3:0] avs_byteenable, // Write byte lanes
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic normal_request_line_n, // Normal interrupt request, active low
  output logic fast_request_line_n // Fast interrupt request, active low
);
  vpic_pkg::vpic_bus_e bus_q;
  logic [2:0] prio_q [32];
  logic [1:0] trig_q [32];
  logic [31:0] vec_q [32];
  logic [31:0] spur_q;
  logic [31:0] mask_q;
  logic [31:0] force_q;
  logic [4:0] stk_idx_q [8];
  logic [2:0] stk_prio_q [8];
  logic [3:0] sp_q;
  logic [31:0] rdata_q;
  logic sel_valid_q;
  logic [4:0] sel_idx_q;
  logic [2:0] sel_prio_q;
  logic normal_request_line_n_n_q;
  logic fast_request_line_n_n_q;
  logic [31:0] pend;
  logic [31:0] set_p;
  logic [31:0] clr_p;
  logic [31:0] cand;
  logic found;
  logic [4:0] win_idx;
  logic [2:0] win_prio;
  logic cur_valid;
  logic [4:0] cur_idx;
  logic [2:0] cur_prio;
  logic hit;
  logic [8:0] ofs;
  logic accept;
  logic wr_acc;
  logic rd_acc;
  logic ivr_rd;
  logic fvr_rd;
  logic eoi_wr;
  logic irq_cond;
  logic fiq_cond;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge

  function automatic logic is_reg(input logic [8:0] o, input logic [8:0] target);
    return o == target;
  endfunction : is_reg

  localparam int unsigned OFS_W_HI = vpic_pkg::OFS_W;
  assign hit = avs_address[31:OFS_W_HI] == vpic_pkg::BASE_ADDR[31:OFS_W_HI];
  assign ofs = avs_address[8:0];

  // Every access is answered one cycle after it is seen; unmapped reads return zero
  assign avs_waitrequest = (avs_read || avs_write) && (bus_q != vpic_pkg::BUS_ANSWER);
  assign accept = ce && (bus_q == vpic_pkg::BUS_ANSWER) && (avs_read || avs_write);
  assign wr_acc = accept && avs_write && hit;
  assign rd_acc = accept && avs_read && hit;
  assign ivr_rd = rd_acc && is_reg(ofs, vpic_pkg::OFS_IVR);
  assign fvr_rd = rd_acc && is_reg(ofs, vpic_pkg::OFS_FVR);
  assign eoi_wr = wr_acc && is_reg(ofs, vpic_pkg::OFS_EOI);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_q <= vpic_pkg::BUS_IDLE;
    end else if (ce) begin
      case (bus_q)
        vpic_pkg::BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_q <= vpic_pkg::BUS_ANSWER;
          end
        end
        vpic_pkg::BUS_ANSWER: bus_q <= vpic_pkg::BUS_IDLE;
        default: bus_q <= vpic_pkg::BUS_IDLE;
      endcase
    end
  end

  // Source input stages
  generate
    for (genvar s = 0; s < 32; s++) begin : g_src
      assign set_p[s] = wr_acc && is_reg(ofs, vpic_pkg::OFS_ISET) && avs_writedata[s];
      // Forced sources belong to the fast path and survive a vector read
      assign clr_p[s] = (wr_acc && is_reg(ofs, vpic_pkg::OFS_ICLR) && avs_writedata[s])
                     || (ivr_rd && sel_valid_q && sel_idx_q == 5'(s) && !force_q[s])
                     || (fvr_rd && s == 0);
      vpic_src_stage u_stage (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .raw_in(src_in[s]),
        .trig(trig_q[s]),
        .set_p(set_p[s]),
        .clr_p(clr_p[s]),
        .active(pend[s])
      );
    end
  endgenerate

  // Mode and handler vector registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < 32; i++) begin
        prio_q[i] <= vpic_pkg::PRIO_RST;
        trig_q[i] <= vpic_pkg::TRIG_RST;
        vec_q[i] <= vpic_pkg::VEC_RST;
      end
      spur_q <= vpic_pkg::SPUR_RST;
    end else if (ce && wr_acc) begin
      if (ofs < vpic_pkg::OFS_VEC && avs_byteenable[0]) begin
        prio_q[ofs[6:2]] <= avs_writedata[vpic_pkg::PRIO_LSB +: vpic_pkg::PRIO_W];
        trig_q[ofs[6:2]] <= avs_writedata[vpic_pkg::TRIG_LSB +: vpic_pkg::TRIG_W];
      end else if (ofs >= vpic_pkg::OFS_VEC && ofs < vpic_pkg::OFS_IVR) begin
        vec_q[ofs[6:2]] <= be_merge(vec_q[ofs[6:2]], avs_writedata, avs_byteenable);
      end else if (is_reg(ofs, vpic_pkg::OFS_SPUR)) begin
        spur_q <= be_merge(spur_q, avs_writedata, avs_byteenable);
      end
    end
  end

  // Enable mask and fast forcing, each set and cleared by its own command word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mask_q <= vpic_pkg::MASK_RST;
      force_q <= vpic_pkg::MASK_RST;
    end else if (ce && wr_acc) begin
      if (is_reg(ofs, vpic_pkg::OFS_IEN)) begin
        mask_q <= mask_q | avs_writedata;
      end else if (is_reg(ofs, vpic_pkg::OFS_IDIS)) begin
        mask_q <= mask_q & ~avs_writedata;
      end else if (is_reg(ofs, vpic_pkg::OFS_FFEN)) begin
        force_q <= force_q | {avs_writedata[31:1], 1'b0};
      end else if (is_reg(ofs, vpic_pkg::OFS_FFDIS)) begin
        force_q <= force_q & ~avs_writedata;
      end
    end
  end

  // Arbitration over sources 1..31, excluding forced ones
  assign cand = pend & mask_q & ~force_q & 32'hFFFF_FFFE;
  vpic_prio_sel u_sel (
    .cand(cand),
    .prio(prio_q),
    .found(found),
    .win_idx(win_idx),
    .win_prio(win_prio)
  );

  assign cur_valid = sp_q != 4'h0;
  assign cur_idx = cur_valid ? stk_idx_q[3'(sp_q - 4'h1)] : 5'h00;
  assign cur_prio = cur_valid ? stk_prio_q[3'(sp_q - 4'h1)] : 3'h0;
  assign irq_cond = found && (!cur_valid || win_prio > cur_prio);
  assign fiq_cond = (pend[0] && mask_q[0]) || |(pend & mask_q & force_q);

  // Selection is frozen when the read is first seen, so data and side effects agree
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_valid_q <= 1'b0;
      sel_idx_q <= 5'h00;
      sel_prio_q <= 3'h0;
    end else if (ce && bus_q == vpic_pkg::BUS_IDLE && avs_read) begin
      sel_valid_q <= irq_cond;
      sel_idx_q <= win_idx;
      sel_prio_q <= win_prio;
    end
  end

  // Nesting stack; a full stack cannot be pushed since each push needs a strictly higher level
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sp_q <= 4'h0;
      for (int i = 0; i < 8; i++) begin
        stk_idx_q[i] <= 5'h00;
        stk_prio_q[i] <= 3'h0;
      end
    end else if (ce) begin
      if (ivr_rd && sel_valid_q && sp_q != 4'(vpic_pkg::STACK_DEPTH)) begin
        stk_idx_q[sp_q[2:0]] <= sel_idx_q;
        stk_prio_q[sp_q[2:0]] <= sel_prio_q;
        sp_q <= sp_q + 4'h1;
      end else if (eoi_wr && cur_valid) begin
        sp_q <= sp_q - 4'h1;
      end
    end
  end

  // Read data
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (ce && bus_q == vpic_pkg::BUS_IDLE && avs_read) begin
      rdata_q <= 32'h0000_0000;
      if (hit) begin
        if (ofs < vpic_pkg::OFS_VEC) begin
          rdata_q[vpic_pkg::PRIO_LSB +: vpic_pkg::PRIO_W] <= prio_q[ofs[6:2]];
          rdata_q[vpic_pkg::TRIG_LSB +: vpic_pkg::TRIG_W] <= trig_q[ofs[6:2]];
        end else if (ofs < vpic_pkg::OFS_IVR) begin
          rdata_q <= vec_q[ofs[6:2]];
        end else begin
          case (ofs)
            vpic_pkg::OFS_IVR: rdata_q <= irq_cond ? vec_q[win_idx] : spur_q;
            vpic_pkg::OFS_FVR: rdata_q <= vec_q[0];
            vpic_pkg::OFS_CUR: rdata_q <= {27'h000_0000, cur_idx};
            vpic_pkg::OFS_PEND: rdata_q <= pend;
            vpic_pkg::OFS_MASK: rdata_q <= mask_q;
            vpic_pkg::OFS_LINES: rdata_q <= {30'h0000_0000, ~fast_request_line_n_n_q, ~normal_request_line_n_n_q};
            vpic_pkg::OFS_SPUR: rdata_q <= spur_q;
            vpic_pkg::OFS_FFSTAT: rdata_q <= force_q;
            default: rdata_q <= 32'h0000_0000;
          endcase
        end
      end
    end
  end
  assign avs_readdata = rdata_q;

  // Request lines; a vector read forces the normal line high on the edge that takes it, before the raised level takes over
  always_ff @(posedge core_clk) begin
    if (rst) begin
      normal_request_line_n_n_q <= 1'b1;
      fast_request_line_n_n_q <= 1'b1;
    end else if (ce) begin
      normal_request_line_n_n_q <= ~irq_cond || ivr_rd;
      fast_request_line_n_n_q <= ~fiq_cond || fvr_rd;
    end
  end
  assign normal_request_line_n = normal_request_line_n_n_q;
  assign fast_request_line_n = fast_request_line_n_n_q;
endmodule : vpic_ctrl

// >>> bench/vpic_ctrl_props.sv
// Port-level assertions for the interrupt controller top.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
module vpic_ctrl_props (
  input wire logic core_clk, // Clock
  input wire logic rst, // Reset
  input wire logic ce, // Enable
  input wire logic [31:0] src_in, // Sources
  input wire logic [31:0] avs_address, // Address
  input wire logic [3:0] avs_byteenable, // Lanes
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire logic normal_request_line_n, // Normal line
  input wire logic fast_request_line_n // Fast line
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic req;
  logic ivr_take;
  assign req = avs_read || avs_write;
  assign ivr_take = avs_read && !avs_waitrequest && ce && avs_address == 32'hFFFF_F100;
  wait_one_a: assert property (req && avs_waitrequest && ce ##1 ce |-> !avs_waitrequest)
    else $error("wait state longer than one cycle");
  wait_first_a: assert property ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest)
    else $error("new request answered without a wait state");
  idle_nowait_a: assert property (!req |-> !avs_waitrequest)
    else $error("stall raised with no request");
  ans_once_a: assert property (req && !avs_waitrequest |=> avs_waitrequest || !req)
    else $error("answer held for more than one cycle");
  off_base_a: assert property (avs_read && !avs_waitrequest && avs_address[31:12] != 20'hF_FFFF
    |-> avs_readdata == 32'h0000_0000) else $error("off-base read returned data");
  rst_idle_a: assert property ($fell(rst) |-> normal_request_line_n && fast_request_line_n)
    else $error("request line active right after reset");
  ivr_drop_a: assert property (ivr_take |=> normal_request_line_n)
    else $error("vector read left normal request asserted");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");
endmodule : vpic_ctrl_props

// >>> bench/vpic_core_model.sv
// Behavioural processor core: takes normal requests unless its interrupt mask is set; takes fast requests always.
// Assumes the bench drives the mask bit as interrupt software would.
`timescale 1ns/1ps
module vpic_core_model (
  input wire logic core_clk, // Clock
  input wire logic rst, // Reset
  input wire logic normal_request_line_n, // Normal request
  input wire logic fast_request_line_n, // Fast request
  input wire logic core_mask, // Mask bit of core_status_word
  output logic irq_take, // Normal entry taken
  output logic fiq_take // Fast entry taken
);
  always_ff @(posedge core_clk) begin
    irq_take <= !rst && !normal_request_line_n && !core_mask;
    fiq_take <= !rst && !fast_request_line_n;
  end
endmodule : vpic_core_model

// >>> bench/tb_vectored_priority_irq_ctrl.sv
// Self-checking bench: priority model with a nesting stack, compared at every result.
// Assumes the design answers each bus access and that ce stays high.
`timescale 1ns/1ps
module tb_vectored_priority_irq_ctrl;
  logic core_clk = 0, rst = 1, avs_read = 0, avs_write = 0, core_mask = 1;
  logic [31:0] src_in = 32'h0000_0000, avs_address = 32'h0000_0000, avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, rd, r;
  logic avs_waitrequest, normal_request_line_n, fast_request_line_n, irq_take;
  int num_errors = 0, check_count = 0, seed = 32'h0945_4956, prio[32], w, k;
  bit en[32];
  int stk[$];
  always #2 core_clk = ~core_clk;
  vpic_ctrl dut_u (.core_clk(core_clk), .rst(rst), .ce(1'b1), .src_in(src_in), .avs_address(avs_address),
    .avs_byteenable(4'hF), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .normal_request_line_n(normal_request_line_n), .fast_request_line_n(fast_request_line_n));
  vpic_core_model core_u (.core_clk(core_clk), .rst(rst), .normal_request_line_n(normal_request_line_n),
    .fast_request_line_n(fast_request_line_n), .core_mask(core_mask), .irq_take(irq_take), .fiq_take());
  function automatic logic [31:0] vec(int i);
    return 32'h0010_0000 + 32'(i) * 32'h0000_0010;
  endfunction : vec
  function automatic int lvl();
    return stk.size() ? prio[stk[$]] : -1;
  endfunction : lvl
  // Scanning downwards with >= lets the lowest number win a tie
  function automatic int win();
    int b = -1;
    for (int i = 31; i >= 1; i--)
      if (src_in[i] && en[i] && prio[i] > lvl() && (b < 0 || prio[i] >= prio[b])) b = i;
    return b;
  endfunction : win
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic cmp_bit(input logic g, input logic e);
    cmp({31'h0, g}, {31'h0, e});
  endtask : cmp_bit
  task automatic bus(input logic wr_en, input logic [31:0] a, input logic [31:0] d);
    int n = 0;
    avs_address <= a;
    avs_read <= !wr_en;
    avs_write <= wr_en;
    avs_writedata <= d;
    // Waitrequest and read data are taken as they stood just before the edge
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // One idle edge keeps a following request from reusing this time step
    @(posedge core_clk);
    if (n >= 50) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : bus
  task automatic wr(input logic [8:0] o, input logic [31:0] d);
    bus(1'b1, vpic_pkg::BASE_ADDR + 32'(o), d);
  endtask : wr
  task automatic chk(input logic [8:0] o, input logic [31:0] e);
    bus(1'b0, vpic_pkg::BASE_ADDR + 32'(o), 32'h0000_0000);
    cmp(rd, e);
  endtask : chk
  task automatic ivr();
    w = win();
    chk(vpic_pkg::OFS_IVR, w < 0 ? 32'h5A5A_0000 : vec(w));
    if (w >= 0) stk.push_back(w);
    chk(vpic_pkg::OFS_CUR, stk.size() ? 32'(stk[$]) : 32'h0000_0000);
  endtask : ivr
  task automatic eoi();
    core_mask <= 1'b1;
    wr(vpic_pkg::OFS_EOI, 32'h0000_0000);
    if (stk.size()) void'(stk.pop_back());
  endtask : eoi
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk(vpic_pkg::OFS_MASK, 32'h0000_0000);
    chk(vpic_pkg::OFS_IVR, 32'h0000_0000);
    bus(1'b0, 32'h0000_0100, 32'h0000_0000);
    cmp(rd, 32'h0000_0000);
    chk(9'h1FC, 32'h0000_0000);
    for (int t = 0; t < 4; t++) begin
      wr(vpic_pkg::OFS_MODE + 9'h00C, 32'(t) << 5);
      src_in[3] <= !t[1];
      repeat (5) @(posedge core_clk);
      wr(vpic_pkg::OFS_ICLR, 32'h0000_0008);
      // The other sources sit in low-level mode with their pins low, so they show as pending
      chk(vpic_pkg::OFS_PEND, 32'hFFFF_FFF7);
      src_in[3] <= t[1];
      repeat (5) @(posedge core_clk);
      chk(vpic_pkg::OFS_PEND, 32'hFFFF_FFFF);
    end
    wr(vpic_pkg::OFS_SPUR, 32'h5A5A_0000);
    for (int i = 1; i < 32; i++) begin
      prio[i] = $random(seed) & 7;
      wr(vpic_pkg::OFS_MODE + 9'(4 * i), 32'(prio[i]) | 32'h0000_0040);
      wr(vpic_pkg::OFS_VEC + 9'(4 * i), vec(i));
    end
    prio[3] = 7;
    for (int m = 0; m < 2; m++) begin
      wr(vpic_pkg::OFS_MODE + 9'h00C, m ? 32'h0000_0047 : 32'h0000_0067);
      src_in[3] <= 1'b0;
      repeat (4) @(posedge core_clk);
      src_in[3] <= 1'b1;
      wr(vpic_pkg::OFS_IEN, 32'h0000_0008);
      en[3] = 1;
      repeat (4) @(posedge core_clk);
      cmp_bit(normal_request_line_n, 1'b0);
      ivr();
      cmp_bit(normal_request_line_n, 1'b1);
      // Source 0 is still in low-level mode with its pin low
      chk(vpic_pkg::OFS_PEND, m ? 32'h0000_0009 : 32'h0000_0001);
      eoi();
      repeat (4) @(posedge core_clk);
      cmp_bit(normal_request_line_n, m == 0);
      wr(vpic_pkg::OFS_IDIS, 32'h0000_0008);
      en[3] = 0;
      src_in[3] <= 1'b0;
    end
    wr(vpic_pkg::OFS_MODE, 32'h0000_0040);
    wr(vpic_pkg::OFS_IEN, 32'h0000_0001);
    src_in[0] <= 1'b1;
    repeat (5) @(posedge core_clk);
    cmp_bit(fast_request_line_n, 1'b0);
    cmp_bit(normal_request_line_n, 1'b1);
    wr(vpic_pkg::OFS_IDIS, 32'h0000_0001);
    src_in[0] <= 1'b0;
    wr(vpic_pkg::OFS_IEN, 32'hFFFF_FFFE);
    for (int i = 1; i < 32; i++) en[i] = 1;
    chk(vpic_pkg::OFS_MASK, 32'hFFFF_FFFE);
    repeat (120) begin
      r = $random(seed);
      case (r[1:0])
        2'd0: src_in <= r & 32'hFFFF_FFFE;
        2'd1: begin
          k = r[6:2];
          if (k != 0) begin
            wr(en[k] ? vpic_pkg::OFS_IDIS : vpic_pkg::OFS_IEN, 32'h0000_0001 << k);
            en[k] = !en[k];
          end
        end
        2'd2: begin
          core_mask <= 1'b0;
          repeat (2) @(posedge core_clk);
          cmp_bit(irq_take, win() >= 0);
          ivr();
        end
        default: eoi();
      endcase
      repeat (5) @(posedge core_clk);
      cmp_bit(normal_request_line_n, win() < 0);
    end
    rst <= 1'b1;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    stk.delete();
    chk(vpic_pkg::OFS_MASK, 32'h0000_0000);
    chk(vpic_pkg::OFS_CUR, 32'h0000_0000);
    cmp_bit(normal_request_line_n, 1'b1);
    tally_and_finish();
  end
endmodule : tb_vectored_priority_irq_ctrl
bind vpic_ctrl vpic_ctrl_props chk_u (.core_clk(core_clk), .rst(rst), .ce(ce), .src_in(src_in),
  .avs_address(avs_address), .avs_byteenable(avs_byteenable), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .normal_request_line_n(normal_request_line_n), .fast_request_line_n(fast_request_line_n));
